// ---- pkg/system_watchdog_pkg.sv ----
// Constants for the system watchdog timer.
// Assumes a single 20 MHz system clock.
package system_watchdog_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SECOND_S      = 1;
  localparam int unsigned MINUTE_S      = 60;
  localparam int unsigned CYC_PER_SEC   = CLK_HZ * SECOND_S;
  localparam int unsigned TIMEOUT_W     = 32;
  localparam int unsigned COUNT_W       = 26;
  localparam logic [31:0] SECOND_LIMIT  = 32'h0000_00ff;
  localparam logic [31:0] SECS_PER_MIN  = 32'h0000_003c;
  localparam logic [31:0] TIMEOUT_RST   = 32'h0000_0000;
  localparam logic [25:0] COUNT_RST     = 26'h000_0000;
  localparam int unsigned RESET_PULSE   = 16;
endpackage

// ---- core/system_watchdog.sv ----
// System watchdog: counts down a programmed timeout and requests a system
// reset on expiry. Commands are single-cycle pulses from logic on sys_clk.
`timescale 1ns/1ps
// Operation
// [RULE1] Expiry while running raises a reset request to the whole system.
// [RULE2] Values 0 through 255 count that many one-second ticks.
// [RULE3] Values above 255 count value/60+1 one-minute ticks.
// [RULE4] Start loads the programmed timeout and begins counting down.
// [RULE5] Reload restores the running count to the last programmed timeout.
// [RULE6] Stop halts counting so no reset occurs until the next start.
// [RULE7] Software must reload or stop before each countdown expires.
// [RULE8] Software must initialize before any other command.
// [RULE9] A new timeout does not disturb the count until start or reload.
module system_watchdog #(
  parameter int unsigned CYC_PER_SEC = system_watchdog_pkg::CYC_PER_SEC,
  parameter int unsigned RESET_PULSE = system_watchdog_pkg::RESET_PULSE
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Commands
  input  wire logic        watchdog_initialize,
  input  wire logic        timeout_program,
  input  wire logic [31:0] timeout_value,
  input  wire logic        countdown_begin,
  input  wire logic        countdown_reload,
  input  wire logic        countdown_halt,
  // Status and reset request
  output logic             running_r,
  output logic             ready_r,
  output logic             sys_reset_req_r
);

  logic [31:0] timeout_r;
  logic [31:0] units_r;
  logic        minutes_r;
  logic [25:0] tick_cnt_r;
  logic [5:0]  min_cnt_r;
  logic        unit_tick;
  logic        load;
  logic [7:0]  pulse_cnt_r;
  logic        expire;

  // Convert a programmed value into a tick count; the resolution is set separately at load
  function automatic logic [31:0] to_units(input logic [31:0] v);
    if (v > system_watchdog_pkg::SECOND_LIMIT)
      to_units = v / system_watchdog_pkg::SECS_PER_MIN + 32'h1; // RULE3
    else
      to_units = v; // RULE2
  endfunction

  assign load   = ready_r && (countdown_begin || countdown_reload);
  assign expire = running_r && (units_r == 32'h0);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ready_r <= 1'b0;
    end else if (watchdog_initialize) begin
      ready_r <= 1'b1; // RULE8
    end
  end

  // Held timeout only moves into the count on start or reload
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timeout_r <= system_watchdog_pkg::TIMEOUT_RST;
    end else if (ready_r && timeout_program) begin
      timeout_r <= timeout_value; // RULE9
    end
  end

  // Second prescaler and minute prescaler
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= system_watchdog_pkg::COUNT_RST;
      min_cnt_r  <= 6'h00;
    end else if (load || !running_r) begin
      tick_cnt_r <= system_watchdog_pkg::COUNT_RST;
      min_cnt_r  <= 6'h00;
    end else if (tick_cnt_r == 26'(CYC_PER_SEC - 1)) begin
      tick_cnt_r <= system_watchdog_pkg::COUNT_RST;
      if (min_cnt_r == 6'(system_watchdog_pkg::MINUTE_S - 1))
        min_cnt_r <= 6'h00;
      else
        min_cnt_r <= min_cnt_r + 6'h01;
    end else begin
      tick_cnt_r <= tick_cnt_r + 26'h1;
    end
  end

  assign unit_tick = (tick_cnt_r == 26'(CYC_PER_SEC - 1)) &&
                     (!minutes_r ||
                      min_cnt_r == 6'(system_watchdog_pkg::MINUTE_S - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      running_r <= 1'b0;
      units_r   <= 32'h0;
      minutes_r <= 1'b0;
    end else if (ready_r && countdown_halt) begin
      running_r <= 1'b0; // RULE6
    end else if (load && (countdown_begin || running_r)) begin
      running_r <= 1'b1; // RULE4
      units_r   <= to_units(timeout_r); // RULE5
      minutes_r <= timeout_r > system_watchdog_pkg::SECOND_LIMIT;
    end else if (expire) begin
      running_r <= 1'b0; // RULE1
    end else if (running_r && unit_tick) begin
      units_r <= units_r - 32'h1;
    end
  end

  // Stretched reset request on expiry
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt_r     <= 8'h00;
      sys_reset_req_r <= 1'b0;
    end else if (expire && !(ready_r && (countdown_halt || load))) begin
      pulse_cnt_r     <= 8'(RESET_PULSE - 1);
      sys_reset_req_r <= 1'b1; // RULE1
    end else if (pulse_cnt_r != 8'h00) begin
      pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end else begin
      sys_reset_req_r <= 1'b0;
    end
  end

  reset_on_expiry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (expire && !countdown_halt && !load) |=> sys_reset_req_r) // RULE1
    else $error("expiry did not request reset");

  halt_stops_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ready_r && countdown_halt) |=> !running_r) // RULE6
    else $error("halt did not stop countdown");

  halted_no_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!running_r && !$past(running_r)) |-> !$rose(sys_reset_req_r)) // RULE6
    else $error("reset while halted");

  begin_loads_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ready_r && countdown_begin && !countdown_halt) |=>
      (running_r && units_r == to_units($past(timeout_r)))) // RULE4
    else $error("start did not load timeout");

  reload_restores_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ready_r && running_r && countdown_reload && !countdown_halt) |=>
      units_r == to_units($past(timeout_r))) // RULE5
    else $error("reload did not restore timeout");

  minute_scale_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(units_r) && minutes_r && running_r && !$past(load) |->
      $past(min_cnt_r) == 6'(system_watchdog_pkg::MINUTE_S - 1)) // RULE3
    else $error("minute tick at wrong time");

  second_scale_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(units_r) && running_r && !$past(load) |->
      $past(tick_cnt_r) == 26'(CYC_PER_SEC - 1)) // RULE2
    else $error("second tick at wrong time");

  program_holds_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (timeout_program && !load && running_r && !unit_tick &&
     !countdown_halt && !expire) |=> $stable(units_r)) // RULE9
    else $error("program disturbed countdown");

  init_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ready_r |=> !running_r) // RULE8
    else $error("ran before initialize");

  // Expiry ends the run; a fresh start is needed afterwards
  expiry_ends_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (expire && !countdown_halt && !load) |=> !running_r) // RULE1
    else $error("still running after expiry");

  // Stretch counter is loaded with RESET_PULSE-1 when the request rises
  pulse_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(sys_reset_req_r) |->
      pulse_cnt_r == 8'(RESET_PULSE - 1)) // RULE1
    else $error("reset stretch not loaded");

  // Request may not drop while stretch cycles remain
  pulse_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (sys_reset_req_r && pulse_cnt_r != 8'h00) |=> sys_reset_req_r) // RULE1
    else $error("reset request dropped early");

  // Each tick removes exactly one unit from the count
  unit_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($changed(units_r) && running_r && !$past(load)) |->
      units_r == $past(units_r) - 32'h1) // RULE2
    else $error("count moved by more than one");

  // Second prescaler never passes its terminal count
  second_range_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    tick_cnt_r <= 26'(CYC_PER_SEC - 1)) // RULE2
    else $error("second prescaler overran");

  // Minute prescaler never passes its terminal count
  minute_range_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    min_cnt_r <= 6'(system_watchdog_pkg::MINUTE_S - 1)) // RULE3
    else $error("minute prescaler overran");

  // Start picks the resolution from the held timeout
  minute_select_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ready_r && countdown_begin && !countdown_halt) |=>
      minutes_r == ($past(timeout_r) >
                    system_watchdog_pkg::SECOND_LIMIT)) // RULE3
    else $error("wrong resolution selected");

  // Reload while stopped must not restart the countdown
  reload_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!running_r && countdown_reload && !countdown_begin) |=>
      !running_r) // RULE5
    else $error("reload started a stopped timer");

  // Prescalers sit cleared while stopped so a restart is a full unit
  idle_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !running_r |=> tick_cnt_r == system_watchdog_pkg::COUNT_RST) // RULE6
    else $error("prescaler ran while stopped");

endmodule // system_watchdog

// ---- bench/system_watchdog_test.sv ----
// Self-checking bench for the system watchdog timer.
// Assumes one second shortened to CPS clock cycles at the design.
`timescale 1ns/1ps
module system_watchdog_test;
  localparam int CPS = 10;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [4:0]  cmd     = 5'h00;
  logic [31:0] tval    = 32'h0000_0000;
  logic        running_r;
  logic        ready_r;
  logic        sys_reset_req_r;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          n;
  always #25 sys_clk = ~sys_clk;
  system_watchdog #(.CYC_PER_SEC(CPS), .RESET_PULSE(16)) dut (
    .sys_clk(sys_clk), .rstn(rstn),
    .watchdog_initialize(cmd[4]), .timeout_program(cmd[3]),
    .timeout_value(tval), .countdown_begin(cmd[2]),
    .countdown_reload(cmd[1]), .countdown_halt(cmd[0]),
    .running_r(running_r), .ready_r(ready_r),
    .sys_reset_req_r(sys_reset_req_r));
  task give_verdict;
    $display("mismatches %0d of %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task chk_in(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error %0t: delay %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // One-cycle command pulse, taken at the second edge
  task go(input logic [4:0] c, input logic [31:0] v);
    @(posedge sys_clk);
    cmd  <= c;
    tval <= v;
    @(posedge sys_clk);
    cmd  <= 5'h00;
  endtask
  task til_rst(output int k);
    k = 0;
    while (sys_reset_req_r !== 1'b1) begin
      @(negedge sys_clk);
      k++;
      if (k > 5000) begin
        n_mismatch++;
        $display("Error %0t: no reset request", $time);
        give_verdict;
      end
    end
  endtask
  task s_expire(input logic [31:0] v, input int cyc);
    go(5'h08, v);
    go(5'h04, 32'h0000_0000);
    til_rst(n);
    chk_in(n, cyc - 1, cyc + 3);
    chk_eq(running_r, 1'b0);
    n = 0;
    while (sys_reset_req_r === 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk_eq(n, 32'h0000_0010);
  endtask
  task s_reload;
    go(5'h08, 32'h0000_0005);
    go(5'h04, 32'h0000_0000);
    repeat (10) @(negedge sys_clk);
    go(5'h08, 32'h0000_0002);
    repeat (25) @(negedge sys_clk);
    chk_eq({running_r, sys_reset_req_r}, 32'h0000_0002);
    go(5'h02, 32'h0000_0000);
    til_rst(n);
    chk_in(n, 2 * CPS - 1, 2 * CPS + 3);
    repeat (20) @(negedge sys_clk);
  endtask
  task s_halt;
    go(5'h08, 32'h0000_0003);
    go(5'h04, 32'h0000_0000);
    repeat (10) @(negedge sys_clk);
    go(5'h01, 32'h0000_0000);
    @(negedge sys_clk);
    chk_eq(running_r, 1'b0);
    n = 0;
    repeat (60) begin
      @(negedge sys_clk);
      if (sys_reset_req_r !== 1'b0) n++;
    end
    chk_eq(n, 32'h0000_0000);
    chk_eq({running_r, sys_reset_req_r}, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk_eq({running_r, ready_r, sys_reset_req_r}, 32'h0000_0000);
    go(5'h08, 32'h0000_0001);
    go(5'h04, 32'h0000_0000);
    @(negedge sys_clk);
    chk_eq({running_r, ready_r}, 32'h0000_0000);
    go(5'h10, 32'h0000_0000);
    @(negedge sys_clk);
    chk_eq(ready_r, 1'b1);
    s_expire(32'h0000_0005, 5 * CPS);
    s_expire(32'h0000_0000, 0);
    s_expire(32'h0000_00ff, 255 * CPS);
    s_expire(32'h0000_0100, 5 * 60 * CPS);
    s_expire(32'h0000_0190, 7 * 60 * CPS);
    s_reload;
    s_halt;
    give_verdict;
  end
endmodule // system_watchdog_test
